// ===== pkg/sfe_defines.svh
// constants shared by the flash device end and the spi host end
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// opcodes
`define SFE_OP_WREN 8'h06
`define SFE_OP_RDSR1 8'h05
`define SFE_OP_RDSR2 8'h35
`define SFE_OP_READ 8'h03
`define SFE_OP_FREAD 8'h0B
`define SFE_OP_SE 8'h20
`define SFE_OP_BE32 8'h52
`define SFE_OP_BE64 8'hD8
`define SFE_OP_CE1 8'hC7
`define SFE_OP_CE2 8'h60
`define SFE_OP_SUSP 8'h75
`define SFE_OP_RESM 8'h7A
`define SFE_OP_WRSR1 8'h01
`define SFE_OP_WRSR2 8'h31
`define SFE_OP_PP 8'h02
`define SFE_OP_QPP 8'h32
`define SFE_OP_PSR 8'h42
`define SFE_OP_ESR 8'h44

// frame bit counts
`define SFE_OP_BITS 8
`define SFE_ADDR_BITS 24
`define SFE_ADDR_END 32
`define SFE_DUMMY_END 40
`define SFE_CNT_MAX 6'h3F

// region sizes as address widths
`define SFE_SEC_AW 12
`define SFE_B32_AW 15
`define SFE_B64_AW 16

// status byte layout
`define SFE_SR1_BUSY 0
`define SFE_SR1_WEL 1
`define SFE_SR1_BP_LO 2
`define SFE_SR1_TB 5
`define SFE_SR1_SEC 6
`define SFE_SR2_SUS 7
`define SFE_ERASED 8'hFF

// timing
`define SFE_CLK_NS 4
`define SFE_RESUME_NS 200
`define SFE_RESUME_CYC (`SFE_RESUME_NS / `SFE_CLK_NS)

// host register offsets
`define SFE_REG_CMD 4'h0
`define SFE_REG_ADDR 4'h1
`define SFE_REG_RDATA 4'h2
`define SFE_REG_STAT 4'h3

`endif

// ===== pkg/sfe_pkg.sv
// types shared by the flash device end and the spi host end
package sfe_pkg;

  // device frame phases, one-hot
  typedef enum logic [5:0] {
    SFE_P_CMD = 6'h01,
    SFE_P_ADDR = 6'h02,
    SFE_P_DUMMY = 6'h04,
    SFE_P_DATA = 6'h08,
    SFE_P_END = 6'h10,
    SFE_P_SKIP = 6'h20
  } sfe_phase_type;

  // host sequencer states, one-hot
  typedef enum logic [2:0] {
    SFE_H_IDLE = 3'h1,
    SFE_H_RUN = 3'h2,
    SFE_H_GAP = 3'h4
  } sfe_hstate_type;

endpackage : sfe_pkg

// ===== pkg/sfe_spi_if.sv
// single spi link between host and flash device
interface sfe_spi_if;
  logic sclk;
  logic cs_n;
  logic si;
  logic so_o;
  logic so_oe;
  logic so_line;

  // released output line reads high through a pull-up
  assign so_line = so_oe ? so_o : 1'b1;

  modport dev (
    input sclk,
    input cs_n,
    input si,
    output so_o,
    output so_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output si,
    input so_line
  );
endinterface : sfe_spi_if

// ===== hw/sfe_flash_dev.sv
// serial nor flash end: erase, suspend/resume, read and fast read
//
// The implementer's own choices: the strobed register port and the register offsets.
`include "sfe_defines.svh"

module sfe_flash_dev
  import sfe_pkg::*;
#(
  parameter int MEM_AW = 17,
  parameter int SUS_LAT_CYC = 64
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sfe_spi_if.dev spi,
  input wire logic prot_tb,
  input wire logic prot_sec,
  input wire logic [2:0] prot_bp,
  output logic busy,
  output logic write_enable_latch,
  output logic suspend_status
);

  generate
    if (MEM_AW < `SFE_B64_AW || MEM_AW > `SFE_ADDR_BITS ||
        SUS_LAT_CYC < 1 || SUS_LAT_CYC > 65535 || `SFE_RESUME_CYC < 1)
    begin : g_bad_param
      $error("sfe_flash_dev: unsupported parameter value");
    end
  endgenerate

  localparam int unsigned MEM_BYTES = 32'd1 << MEM_AW;

  logic [7:0] mem [0:MEM_BYTES-1];
  logic [7:0] in_s1_r;
  logic [7:0] in_s2_r;
  logic sclk_d_r;
  logic cs_d_r;
  sfe_phase_type phase_r;
  logic [5:0] cnt_r;
  logic [29:0] sh_r;
  logic [7:0] op_r;
  logic [23:0] addr_r;
  logic [7:0] dsh_r;
  logic [2:0] dbit_r;
  logic so_r;
  logic so_oe_r;
  logic busy_r;
  logic wel_r;
  logic sus_r;
  logic chip_r;
  logic [MEM_AW-1:0] ptr_r;
  logic [MEM_AW:0] left_r;
  logic [15:0] lat_r;

  // synchronised pins; stage one is read only by stage two
  logic sclk_s;
  logic cs_s;
  logic si_s;
  logic tb_s;
  logic sec_s;
  logic [2:0] bp_s;
  assign {sclk_s, cs_s, si_s, tb_s, sec_s, bp_s} = in_s2_r;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic exec;
  logic walking;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] src;
  int unsigned reg_aw;
  logic [MEM_AW-1:0] base;
  logic erase_ok;

  // status bytes as shifted out
  function automatic logic [7:0] status1(input logic b, input logic w,
                                         input logic t, input logic s,
                                         input logic [2:0] p);
    status1 = 8'h00;
    status1[`SFE_SR1_BUSY] = b;
    status1[`SFE_SR1_WEL] = w;
    status1[`SFE_SR1_BP_LO +: 3] = p;
    status1[`SFE_SR1_TB] = t;
    status1[`SFE_SR1_SEC] = s;
  endfunction : status1

  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == `SFE_OP_SE) || (op == `SFE_OP_BE32) ||
               (op == `SFE_OP_BE64) || (op == `SFE_OP_CE1) ||
               (op == `SFE_OP_CE2);
  endfunction : is_erase

  function automatic logic is_chip(input logic [7:0] op);
    is_chip = (op == `SFE_OP_CE1) || (op == `SFE_OP_CE2);
  endfunction : is_chip

  // region size per erase opcode
  function automatic int unsigned region_aw(input logic [7:0] op);
    if (op == `SFE_OP_SE)
      region_aw = `SFE_SEC_AW;
    else if (op == `SFE_OP_BE32)
      region_aw = `SFE_B32_AW;
    else if (op == `SFE_OP_BE64)
      region_aw = `SFE_B64_AW;
    else
      region_aw = MEM_AW;
  endfunction : region_aw

  // does aligned region [lo, lo+2^aw) touch the protected zone
  function automatic logic prot_hit(input logic [MEM_AW-1:0] lo_a,
                                    input int unsigned aw,
                                    input logic t, input logic s,
                                    input logic [2:0] p);
    int unsigned lo;
    int unsigned hi;
    int unsigned zaw;
    lo = 32'(lo_a);
    hi = lo + (32'd1 << aw);
    zaw = (s ? `SFE_SEC_AW : `SFE_B64_AW) + 32'(p) - 32'd1;
    if (zaw > MEM_AW)
      zaw = MEM_AW;
    if (p == 3'h0)
      prot_hit = 1'b0;
    else if (t)
      prot_hit = lo < (32'd1 << zaw);
    else
      prot_hit = hi > (MEM_BYTES - (32'd1 << zaw));
  endfunction : prot_hit

  // phase that follows the eighth opcode bit
  function automatic sfe_phase_type cmd_next(input logic [7:0] op,
                                             input logic b);
    case (op)
      `SFE_OP_READ, `SFE_OP_FREAD: cmd_next = b ? SFE_P_SKIP : SFE_P_ADDR;
      `SFE_OP_RDSR1, `SFE_OP_RDSR2: cmd_next = SFE_P_DATA;
      `SFE_OP_SE, `SFE_OP_BE32, `SFE_OP_BE64: cmd_next = SFE_P_ADDR;
      `SFE_OP_CE1, `SFE_OP_CE2, `SFE_OP_WREN: cmd_next = SFE_P_END;
      `SFE_OP_SUSP, `SFE_OP_RESM: cmd_next = SFE_P_END;
      // program and status-write opcodes are never run, so always refused
      default: cmd_next = SFE_P_SKIP;
    endcase
  endfunction : cmd_next

  // two-flop synchroniser on every pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1_r <= 8'h40;
      in_s2_r <= 8'h40;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      in_s1_r <= {spi.sclk, spi.cs_n, spi.si, prot_tb, prot_sec, prot_bp};
      in_s2_r <= in_s1_r;
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
  assign cs_rise = cs_s & ~cs_d_r;
  assign exec = cs_rise && (phase_r == SFE_P_END);
  assign walking = busy_r && !sus_r && (left_r != '0);
  assign sr1 = status1(busy_r, wel_r, tb_s, sec_s, bp_s);
  assign sr2 = 8'(sus_r) << `SFE_SR2_SUS;
  assign src = (op_r == `SFE_OP_RDSR1) ? sr1 :
               (op_r == `SFE_OP_RDSR2) ? sr2 :
               mem[addr_r[MEM_AW-1:0]];

  // erase admission; alignment drops low address bits
  always_comb
  begin
    reg_aw = region_aw(op_r);
    base = addr_r[MEM_AW-1:0] & ~MEM_AW'((33'd1 << reg_aw) - 33'd1);
    erase_ok = exec && is_erase(op_r) && !busy_r && wel_r &&
               !sus_r &&
               !prot_hit(base, reg_aw, tb_s, sec_s, bp_s);
  end

  // serial frame: shift in on rise, shift out on fall
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= SFE_P_CMD;
      cnt_r <= 6'h00;
      sh_r <= 30'h0000_0000;
      op_r <= 8'h00;
      addr_r <= 24'h00_0000;
      dsh_r <= 8'h00;
      dbit_r <= 3'h0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end
    else if (cs_s)
    begin
      // deselect ends any frame, reads included
      phase_r <= SFE_P_CMD;
      cnt_r <= 6'h00;
      dbit_r <= 3'h0;
      so_oe_r <= 1'b0;
    end
    else if (sclk_rise)
    begin
      if (cnt_r != `SFE_CNT_MAX)
        cnt_r <= cnt_r + 6'h01;
      sh_r <= {sh_r[28:0], si_s};
      case (phase_r)
        SFE_P_CMD:
          if (cnt_r == 6'(`SFE_OP_BITS - 1))
          begin
            op_r <= {sh_r[6:0], si_s};
            phase_r <= cmd_next({sh_r[6:0], si_s}, busy_r);
          end
        SFE_P_ADDR:
          if (cnt_r == 6'(`SFE_ADDR_END - 1))
          begin
            addr_r <= {sh_r[22:0], si_s};
            if (op_r == `SFE_OP_READ)
              phase_r <= SFE_P_DATA;
            else if (op_r == `SFE_OP_FREAD)
              phase_r <= SFE_P_DUMMY;
            else
              phase_r <= SFE_P_END;
          end
        SFE_P_DUMMY:
          if (cnt_r == 6'(`SFE_DUMMY_END - 1))
            phase_r <= SFE_P_DATA;
        SFE_P_END:
          phase_r <= SFE_P_SKIP;
        default:
          phase_r <= phase_r;
      endcase
    end
    else if (sclk_fall && phase_r == SFE_P_DATA)
    begin
      // msb first; fetch next byte at each byte start
      so_oe_r <= 1'b1;
      dbit_r <= dbit_r + 3'h1;
      if (dbit_r == 3'h0)
      begin
        so_r <= src[7];
        dsh_r <= {src[6:0], 1'b0};
        if (op_r == `SFE_OP_READ || op_r == `SFE_OP_FREAD)
          addr_r <= addr_r + 24'h00_0001;
      end
      else
      begin
        so_r <= dsh_r[7];
        dsh_r <= {dsh_r[6:0], 1'b0};
      end
    end
  end

  // self-timed engine: busy, latch, suspend
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      sus_r <= 1'b0;
      chip_r <= 1'b0;
      ptr_r <= '0;
      left_r <= '0;
      lat_r <= 16'h0000;
    end
    else if (erase_ok)
    begin
      busy_r <= 1'b1;
      chip_r <= is_chip(op_r);
      ptr_r <= base;
      left_r <= (MEM_AW + 1)'(33'd1 << reg_aw);
    end
    else if (exec && op_r == `SFE_OP_WREN && !busy_r)
      wel_r <= 1'b1;
    else if (exec && op_r == `SFE_OP_SUSP && !sus_r && busy_r && !chip_r)
    begin
      sus_r <= 1'b1;
      lat_r <= 16'(SUS_LAT_CYC);
    end
    else if (exec && op_r == `SFE_OP_RESM && sus_r && !busy_r)
    begin
      // busy back on next edge, well inside the resume bound
      sus_r <= 1'b0;
      busy_r <= 1'b1;
    end
    else if (busy_r && sus_r)
    begin
      // walk is frozen; busy drops once latency expires
      lat_r <= lat_r - 16'h0001;
      if (lat_r == 16'h0001)
        busy_r <= 1'b0;
    end
    else if (walking)
    begin
      ptr_r <= ptr_r + 1'b1;
      left_r <= left_r - 1'b1;
      if (left_r == (MEM_AW + 1)'(1))
      begin
        busy_r <= 1'b0;
        wel_r <= 1'b0;
        chip_r <= 1'b0;
      end
    end
  end

  // erase writes one byte per cycle; array has no reset
  always_ff @(posedge clk_sys)
  begin
    if (walking)
      mem[ptr_r] <= `SFE_ERASED;
  end

  assign spi.so_o = so_r;
  assign spi.so_oe = so_oe_r;
  assign busy = busy_r;
  assign write_enable_latch = wel_r;
  assign suspend_status = sus_r;

endmodule : sfe_flash_dev

// ===== hw/sfe_spi_host.sv
// spi host end: runs one flash command per software order
`include "sfe_defines.svh"

module sfe_spi_host
  import sfe_pkg::*;
#(
  parameter int HALF_CYC = 6
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sfe_spi_if.host spi,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // output is sampled two sync stages late; half period must cover it
  generate
    if (HALF_CYC < 6 || HALF_CYC > 255)
    begin : g_bad_param
      $error("sfe_spi_host: HALF_CYC out of range");
    end
  endgenerate

  sfe_hstate_type st_r;
  logic [1:0] so_sync_r;
  logic [23:0] addr_r;
  logic [39:0] sh_r;
  logic [11:0] cnt_r;
  logic [11:0] obits_r;
  logic [11:0] total_r;
  logic [7:0] half_r;
  logic [7:0] rx_r;
  logic [7:0] last_r;
  logic [7:0] nrx_r;
  logic sclk_r;
  logic cs_n_r;
  logic si_r;
  logic [31:0] rdata_r;
  logic [11:0] rcnt;

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = (op == `SFE_OP_READ) || (op == `SFE_OP_FREAD) ||
               (op == `SFE_OP_SE) || (op == `SFE_OP_BE32) ||
               (op == `SFE_OP_BE64);
  endfunction : has_addr

  assign rcnt = cnt_r - obits_r;

  // so line synchroniser
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      so_sync_r <= 2'h3;
    else
      so_sync_r <= {so_sync_r[0], spi.so_line};
  end

  // address register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      addr_r <= 24'h00_0000;
    else if (reg_wr && reg_addr == `SFE_REG_ADDR)
      addr_r <= reg_wdata[23:0];
  end

  // frame sequencer; orders while running are dropped
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= SFE_H_IDLE;
      sh_r <= 40'h00_0000_0000;
      cnt_r <= 12'h000;
      obits_r <= 12'h000;
      total_r <= 12'h000;
      half_r <= 8'h00;
      rx_r <= 8'h00;
      last_r <= 8'h00;
      nrx_r <= 8'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      si_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        SFE_H_IDLE:
          if (reg_wr && reg_addr == `SFE_REG_CMD)
          begin
            sh_r <= {reg_wdata[7:0], addr_r, 8'h00};
            obits_r <= 12'(`SFE_OP_BITS) +
                       (has_addr(reg_wdata[7:0]) ? 12'(`SFE_ADDR_BITS) : 12'h000) +
                       ((reg_wdata[7:0] == `SFE_OP_FREAD) ?
                        12'(`SFE_OP_BITS) : 12'h000);
            total_r <= 12'(`SFE_OP_BITS) +
                       (has_addr(reg_wdata[7:0]) ? 12'(`SFE_ADDR_BITS) : 12'h000) +
                       ((reg_wdata[7:0] == `SFE_OP_FREAD) ?
                        12'(`SFE_OP_BITS) : 12'h000) +
                       {1'b0, reg_wdata[15:8], 3'h0};
            si_r <= reg_wdata[7];
            cs_n_r <= 1'b0;
            cnt_r <= 12'h000;
            half_r <= 8'h00;
            nrx_r <= 8'h00;
            st_r <= SFE_H_RUN;
          end
        SFE_H_RUN:
          if (half_r == 8'(HALF_CYC - 1))
          begin
            half_r <= 8'h00;
            if (!sclk_r)
            begin
              sclk_r <= 1'b1;
              cnt_r <= cnt_r + 12'h001;
              if (cnt_r >= obits_r)
              begin
                // device drove this bit at the previous fall
                rx_r <= {rx_r[6:0], so_sync_r[1]};
                if (rcnt[2:0] == 3'h7)
                begin
                  last_r <= {rx_r[6:0], so_sync_r[1]};
                  nrx_r <= nrx_r + 8'h01;
                end
              end
            end
            else
            begin
              sclk_r <= 1'b0;
              sh_r <= {sh_r[38:0], 1'b0};
              if (cnt_r == total_r)
              begin
                // deselect right after the last whole byte
                cs_n_r <= 1'b1;
                si_r <= 1'b0;
                st_r <= SFE_H_GAP;
              end
              else
                si_r <= sh_r[38];
            end
          end
          else
            half_r <= half_r + 8'h01;
        SFE_H_GAP:
          if (half_r == 8'(HALF_CYC - 1))
          begin
            half_r <= 8'h00;
            st_r <= SFE_H_IDLE;
          end
          else
            half_r <= half_r + 8'h01;
        default:
          st_r <= SFE_H_IDLE;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SFE_REG_ADDR: rdata_r <= {8'h00, addr_r};
        `SFE_REG_RDATA: rdata_r <= {24'h00_0000, last_r};
        `SFE_REG_STAT: rdata_r <= {16'h0000, nrx_r, 7'h00, st_r != SFE_H_IDLE};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else
      rdata_r <= 32'h0000_0000;
  end

  assign spi.sclk = sclk_r;
  assign spi.cs_n = cs_n_r;
  assign spi.si = si_r;
  assign reg_rdata = rdata_r;

endmodule : sfe_spi_host

// ===== testbench/sfe_link_asserts.sv
// concurrent checks on the spi link and the flash status outputs
module sfe_link_asserts #(
  parameter int SUS_LAT_CYC = 64
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic suspend_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // resume must restart the erase within 200 ns at 4 ns a cycle
  localparam int RES_LIM = 50;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // suspend handshake on the status flags
  sus_drop_a: assert property ($rose(suspend_status) |-> ##[1:SUS_LAT_CYC] !busy)
    else $error("busy did not drop after suspend");
  sus_accept_a: assert property ($rose(suspend_status) |-> $past(busy))
    else $error("suspend taken while idle");
  resume_busy_a: assert property ($fell(suspend_status) |-> ##[0:RES_LIM] busy)
    else $error("resume did not restart the erase");
  held_sus_a: assert property ($rose(busy) |-> !suspend_status)
    else $error("erase started while suspended");
  // write enable latch around an erase
  done_wel_a: assert property ($fell(busy) && !suspend_status |-> !write_enable_latch)
    else $error("latch not cleared at erase end");
  start_wel_a: assert property ($rose(busy) |-> $past(write_enable_latch))
    else $error("erase started without write enable");
  wel_idle_a: assert property ($rose(write_enable_latch) |-> !busy)
    else $error("write enable taken while busy");
  // work only starts once the select is released
  start_frame_a: assert property ($rose(busy) |-> cs_n)
    else $error("erase started inside a frame");
  // output drive starts only inside a frame, bits move while the clock is low
  oe_select_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output driven without select");
  so_fall_a: assert property (so_oe && $changed(so_o) |-> !sclk)
    else $error("output bit moved while clock high");

  sus_c: cover property ($rose(suspend_status));
  done_c: cover property ($fell(busy) && !suspend_status);
  read_c: cover property ($rose(so_oe));
endmodule : sfe_link_asserts

// ===== testbench/serial_flash_erase_suspend_read_tb.sv
// self-checking bench: spi host end and flash end joined over one link
module serial_flash_erase_suspend_read_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic rst_n;
  logic prot_tb, prot_sec;
  logic [2:0] prot_bp;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, busy, write_enable_latch, suspend_status;
  logic er [0:65535]; // model of erased bytes
  integer n_fail, n_compared, seed, oe_cnt, oe0;

  sfe_spi_if link();
  sfe_flash_dev #(.MEM_AW(16), .SUS_LAT_CYC(4)) sfe_flash_dev_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi(link), .prot_tb(prot_tb),
    .prot_sec(prot_sec), .prot_bp(prot_bp), .busy(busy), .write_enable_latch(write_enable_latch),
    .suspend_status(suspend_status));
  sfe_spi_host #(.HALF_CYC(6)) sfe_spi_host_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  sfe_link_asserts #(.SUS_LAT_CYC(4)) sfe_link_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n),
    .so_o(link.so_o), .so_oe(link.so_oe), .busy(busy), .write_enable_latch(write_enable_latch),
    .suspend_status(suspend_status));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // counts cycles of device drive, to spot reads that should be ignored
  always @(posedge clk_sys)
  begin
    if (link.so_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_fail++;
    $display("Error at %0t: wait limit used up", $time);
    stop_test();
  endtask : hang

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // one frame: address, order, poll until done, then last byte into rv
  task automatic cmd(input logic [7:0] op, input logic [7:0] n,
                     input logic [23:0] a);
    integer i;
    oe0 = oe_cnt;
    wr(4'h1, {8'h00, a});
    wr(4'h0, {16'h0000, n, op});
    for (i = 0; i < 4000; i++)
    begin
      rd(4'h3, rv);
      if (rv[0] === 1'b0)
        break;
    end
    if (i == 4000)
      hang();
    repeat (8) @(posedge clk_sys);
    rd(4'h2, rv);
  endtask : cmd

  task automatic flags(input logic b, input logic w, input logic s);
    chk({5'h00, busy, write_enable_latch, suspend_status}, {5'h00, b, w, s});
  endtask : flags

  // erase length is the region size in cycles, so bound it above 2^16
  task automatic wait_idle();
    integer i;
    for (i = 0; i < 70000 && busy !== 1'b0; i++)
      @(posedge clk_sys);
    if (i == 70000)
      hang();
  endtask : wait_idle

  initial
  begin
    integer k, n;
    logic [23:0] a;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    prot_tb = 1'b0;
    prot_sec = 1'b1;
    prot_bp = 3'h1; // top 4 KiB zone protected
    oe_cnt = 0;
    n_fail = 0;
    n_compared = 0;
    seed = 32'h8e24_44f8;
    for (k = 0; k < 65536; k++)
      er[k] = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // refusals: no latch, wrong frame length, protection
    cmd(8'h05, 8'h01, 24'h00_0000);
    chk(rv[7:0], {1'b0, prot_sec, prot_tb, prot_bp, 2'b00});
    cmd(8'hD8, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b0, 1'b0);
    cmd(8'h06, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    cmd(8'hC7, 8'h01, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    cmd(8'h52, 8'h01, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    cmd(8'hC7, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    cmd(8'h60, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    cmd(8'hD8, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b0);
    $display("test refusals finished");
    // half block erase from an unaligned address, then suspend and resume
    rv = $random(seed);
    a = {rv[23:16], 1'b0, rv[14:0]};
    cmd(8'h52, 8'h00, a);
    flags(1'b1, 1'b1, 1'b0);
    cmd(8'h05, 8'h01, 24'h00_0000);
    chk(rv[7:0], {1'b0, prot_sec, prot_tb, prot_bp, 2'b11});
    for (k = 0; k < 2; k++)
    begin
      cmd(k[0] ? 8'h0B : 8'h03, 8'h01, 24'h00_0000);
      chk({7'h00, oe_cnt != oe0}, 8'h00);
    end
    cmd(8'h75, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b1);
    cmd(8'h35, 8'h01, 24'h00_0000);
    chk(rv[7:0] & 8'h80, 8'h80);
    cmd(8'h20, 8'h00, 24'h00_9000);
    flags(1'b0, 1'b1, 1'b1);
    cmd(8'h52, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b1);
    cmd(8'h02, 8'h00, 24'h00_9000);
    flags(1'b0, 1'b1, 1'b1);
    cmd(8'h75, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b1, 1'b1);
    // no second suspend follows this resume before the erase ends, keeping the spacing
    cmd(8'h7A, 8'h00, 24'h00_0000);
    flags(1'b1, 1'b1, 1'b0);
    cmd(8'h7A, 8'h00, 24'h00_0000);
    flags(1'b1, 1'b1, 1'b0);
    wait_idle();
    flags(1'b0, 1'b0, 1'b0);
    cmd(8'h75, 8'h00, 24'h00_0000);
    flags(1'b0, 1'b0, 1'b0);
    for (k = 0; k < 32768; k++)
      er[k] = 1'b1;
    $display("test suspend finished");
    // sector erase next door, so a read can cross from unerased bytes
    cmd(8'h06, 8'h00, 24'h00_0000);
    cmd(8'h20, 8'h00, 24'h00_9ABC);
    wait_idle();
    for (k = 36864; k < 40960; k++)
      er[k] = 1'b1;
    // plain and fast reads, boundary first then random spots
    for (k = 0; k < 10; k++)
    begin
      rv = $random(seed);
      a = (k < 2) ? 24'h00_8FFF : {rv[31:24], 1'b0, rv[14:4], 4'h0};
      n = (k < 2) ? 2 : 1 + rv[17:16];
      cmd(k[0] ? 8'h0B : 8'h03, n[7:0], a);
      chk(rv[7:0], er[(a[15:0] + n - 1) & 16'hFFFF] ? 8'hFF : 8'h00);
      rd(4'h3, rv);
      chk(rv[15:8], n[7:0]);
    end
    $display("test reads finished");
    // chip erase runs once unprotected, and cannot be suspended
    @(posedge clk_sys);
    prot_bp <= 3'h0;
    cmd(8'h06, 8'h00, 24'h00_0000);
    cmd(8'hC7, 8'h00, 24'h00_0000);
    flags(1'b1, 1'b1, 1'b0);
    cmd(8'h75, 8'h00, 24'h00_0000);
    flags(1'b1, 1'b1, 1'b0);
    $display("test chip erase finished");
    stop_test();
  end
endmodule : serial_flash_erase_suspend_read_tb
